//--- src/timing_pin_router.sv
// The register addresses and the address-and-strobe port were left to the implementer.
`timescale 1ns/1ns
module timing_pin_router
  import timing_pin_router_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [DATA_W-1:0] o_rdata,
  input wire logic [NUM_PINS-1:0] i_function_pin_in,
  output logic [NUM_PINS-1:0] o_function_pin_out,
  output logic [NUM_PINS-1:0] o_function_pin_oe,
  input wire logic [NUM_PINS-1:0] i_pin_drive_src,
  input wire logic [NUM_DEDICATED-1:0] i_dedicated_src,
  output logic [NUM_DEDICATED-1:0] o_dedicated_out,
  output logic [NUM_DEDICATED-1:0] o_dedicated_oe,
  input wire logic [NUM_ROUTES-1:0] i_internal_timing,
  output logic [NUM_ROUTES-1:0] o_timing_signal,
  output logic [NUM_ROUTES-1:0] o_route_external
);

  // ---------------------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------------------
  logic [NUM_PINS-1:0] pin_drive_en;
  logic [NUM_DEDICATED-1:0] dedicated_en;
  logic [SEL_W-1:0] route_sel [NUM_ROUTES];
  logic [NUM_ROUTES-1:0] route_ext;
  logic [NUM_ROUTES-1:0] route_pol;
  logic [NUM_ROUTES-1:0] route_lvl;
  logic [NUM_ROUTES-1:0] event_seen;
  logic [NUM_ROUTES-1:0] next_timing;
  logic [NUM_ROUTES-1:0] route_event;
  logic [NUM_PINS-1:0] pin_level;
  logic [NUM_PINS-1:0] pin_level_prev;
  logic [DATA_W-1:0] next_rdata;

  // ---------------------------------------------------------------------------
  // decode helpers
  // ---------------------------------------------------------------------------
  function automatic logic route_hit(input logic [ADDR_W-1:0] a);
    return (a >= ROUTE_CFG_BASE) && (a <= ROUTE_CFG_LAST) &&
      (a[1:0] == 2'h0);
  endfunction

  function automatic logic [4:0] route_slot(input logic [ADDR_W-1:0] a);
    logic [ADDR_W-1:0] d;
    d = a - ROUTE_CFG_BASE;
    return d[6:2];
  endfunction

  // a select beyond the last pin reads as a quiet low line
  function automatic logic pin_pick(
    input logic [NUM_PINS-1:0] levels,
    input logic [SEL_W-1:0] sel
  );
    logic bit_out;
    bit_out = 1'b0;
    for (int p = 0; p < NUM_PINS; p++) begin
      if (sel == SEL_W'(p)) begin
        bit_out = levels[p];
      end
    end
    return bit_out;
  endfunction

  // ---------------------------------------------------------------------------
  // pin input synchroniser
  // ---------------------------------------------------------------------------
  // pins enter here
  pin_sync_detect #(
    .WIDTH(NUM_PINS)
  ) u_sync (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_pin(i_function_pin_in),
    .o_level(pin_level),
    .o_level_prev(pin_level_prev)
  );

  // ---------------------------------------------------------------------------
  // software registers
  // ---------------------------------------------------------------------------
  // per-pin driver enable
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      pin_drive_en <= PIN_DRIVE_EN_RST;
    end else if (i_wr && i_addr == PIN_DRIVE_EN_ADDR) begin
      pin_drive_en <= i_wdata[NUM_PINS-1:0];
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      dedicated_en <= DEDICATED_EN_RST;
    end else if (i_wr && i_addr == DEDICATED_EN_ADDR) begin
      dedicated_en <= i_wdata[NUM_DEDICATED-1:0];
    end
  end

  genvar r;
  generate
    for (r = 0; r < NUM_ROUTES; r++) begin : g_cfg
      always_ff @(posedge i_clock) begin
        if (i_rst) begin
          route_sel[r] <= ROUTE_SEL_RST;
          route_ext[r] <= 1'b0;
          route_pol[r] <= 1'b0;
          route_lvl[r] <= 1'b0;
        end else if (i_wr && route_hit(i_addr) &&
                     route_slot(i_addr) == 5'(r)) begin
          route_sel[r] <= i_wdata[SEL_LSB +: SEL_W];
          route_ext[r] <= i_wdata[EXT_BIT];
          route_pol[r] <= i_wdata[POL_BIT];
          route_lvl[r] <= i_wdata[LVL_BIT];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // per-route detection
  // ---------------------------------------------------------------------------
  // current and previous level come from the same pin, so changing the
  // select never fakes an edge
  generate
    for (r = 0; r < NUM_ROUTES; r++) begin : g_route
      logic cur;
      logic prev;
      logic edge_hit;
      assign cur = pin_pick(pin_level, route_sel[r]);
      assign prev = pin_pick(pin_level_prev, route_sel[r]);
      assign edge_hit = route_pol[r] ? (prev & ~cur) : (cur & ~prev);
      assign route_event[r] = route_ext[r] && !route_lvl[r] && edge_hit;
      always_comb begin
        if (!route_ext[r]) begin
          next_timing[r] = i_internal_timing[r];
        end else if (route_lvl[r]) begin
          next_timing[r] = cur ^ route_pol[r];
        end else begin
          next_timing[r] = edge_hit;
        end
      end
    end
  endgenerate

  // sampling every 4 ns catches any pulse that honours the 10 ns minimum
  // pulse width relied on
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_timing_signal <= '0;
    end else begin
      o_timing_signal <= next_timing;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_route_external <= '0;
    end else begin
      o_route_external <= route_ext;
    end
  end

  // sticky capture of detected edges; write one clears, a new edge wins
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      event_seen <= '0;
    end else if (i_wr && i_addr == EVENT_SEEN_ADDR) begin
      event_seen <= (event_seen & ~i_wdata[NUM_ROUTES-1:0]) | route_event;
    end else begin
      event_seen <= event_seen | route_event;
    end
  end

  // ---------------------------------------------------------------------------
  // output drivers
  // ---------------------------------------------------------------------------
  // fixed signal per pin
  // driver enabled means pin is ours
  pin_output_stage #(
    .WIDTH(NUM_PINS)
  ) u_pin_drive (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_src(i_pin_drive_src),
    .i_enable(pin_drive_en),
    .o_out(o_function_pin_out),
    .o_oe(o_function_pin_oe)
  );

  pin_output_stage #(
    .WIDTH(NUM_DEDICATED)
  ) u_dedicated_drive (
    .i_clock(i_clock),
    .i_rst(i_rst),
    .i_src(i_dedicated_src),
    .i_enable(dedicated_en),
    .o_out(o_dedicated_out),
    .o_oe(o_dedicated_oe)
  );

  // ---------------------------------------------------------------------------
  // read path
  // ---------------------------------------------------------------------------
  always_comb begin
    next_rdata = '0;
    if (route_hit(i_addr)) begin
      for (int k = 0; k < NUM_ROUTES; k++) begin
        if (route_slot(i_addr) == 5'(k)) begin
          next_rdata[SEL_LSB +: SEL_W] = route_sel[k];
          next_rdata[EXT_BIT] = route_ext[k];
          next_rdata[POL_BIT] = route_pol[k];
          next_rdata[LVL_BIT] = route_lvl[k];
        end
      end
    end else begin
      case (i_addr)
        PIN_DRIVE_EN_ADDR: begin
          next_rdata[NUM_PINS-1:0] = pin_drive_en;
        end
        DEDICATED_EN_ADDR: begin
          next_rdata[NUM_DEDICATED-1:0] = dedicated_en;
        end
        PIN_LEVEL_ADDR: begin
          next_rdata[NUM_PINS-1:0] = pin_level;
        end
        ROUTE_STATE_ADDR: begin
          next_rdata[NUM_ROUTES-1:0] = o_timing_signal;
        end
        EVENT_SEEN_ADDR: begin
          next_rdata[NUM_ROUTES-1:0] = event_seen;
        end
        default: begin
          next_rdata = '0;
        end
      endcase
    end
  end

  // data only in the cycle after the read strobe, zero otherwise
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_rdata <= RDATA_RST;
    end else if (i_rd) begin
      o_rdata <= next_rdata;
    end else begin
      o_rdata <= RDATA_RST;
    end
  end

endmodule

//--- src/timing_pin_router_pkg.sv
// ---------------------------------------------------------------------------
// Contract
// - all external timing control enters through ten two-way function pins
// - a driving function pin carries its own fixed internal timing signal
// - five dedicated output-only pins carry the remaining timing signals
// - thirteen internal signals, each sourced from a software-chosen pin
// - per-pin software driver enable; disabled pin acts as input only
// - each routed input selects rising or falling edge polarity
// - edge mode accepts arbitrarily long pulses, sees only selected edge
// - level mode imposes no minimum or maximum pulse width; the code samples pins every 4 ns, so pulses shorter than that can be missed
// - every timing output stays undriven until software enables it
// ---------------------------------------------------------------------------
package timing_pin_router_pkg;

  // ---------------------------------------------------------------------------
  // sizes
  // ---------------------------------------------------------------------------
  localparam int NUM_PINS = 10;
  localparam int NUM_DEDICATED = 5;
  localparam int NUM_ROUTES = 13;
  localparam int SEL_W = 4;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // ---------------------------------------------------------------------------
  // register map (byte addresses, one word each)
  // ---------------------------------------------------------------------------
  localparam logic [7:0] PIN_DRIVE_EN_ADDR = 8'h00;
  localparam logic [7:0] DEDICATED_EN_ADDR = 8'h04;
  localparam logic [7:0] PIN_LEVEL_ADDR = 8'h08;
  localparam logic [7:0] ROUTE_STATE_ADDR = 8'h0c;
  localparam logic [7:0] ROUTE_CFG_BASE = 8'h10;
  localparam logic [7:0] ROUTE_CFG_LAST = 8'h40;
  localparam logic [7:0] EVENT_SEEN_ADDR = 8'h44;

  // route configuration fields
  localparam int SEL_LSB = 0;
  localparam int EXT_BIT = 4;
  localparam int POL_BIT = 5;
  localparam int LVL_BIT = 6;

  // reset values: drivers off, every route on its internal source
  localparam logic [NUM_PINS-1:0] PIN_DRIVE_EN_RST = 10'h000;
  localparam logic [NUM_DEDICATED-1:0] DEDICATED_EN_RST = 5'h00;
  localparam logic [SEL_W-1:0] ROUTE_SEL_RST = 4'h0;
  localparam logic [DATA_W-1:0] RDATA_RST = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 4;
  localparam int MIN_PULSE_NS = 10;
  localparam int MIN_PULSE_CYCLES =
    (MIN_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

endpackage

//--- src/pin_sync_detect.sv
`timescale 1ns/1ns
module pin_sync_detect #(
  parameter int WIDTH = 10
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_pin,
  output logic [WIDTH-1:0] o_level,
  output logic [WIDTH-1:0] o_level_prev
);

  logic [WIDTH-1:0] meta;

  // ---------------------------------------------------------------------------
  // two-stage synchroniser plus one history stage per pin
  // ---------------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++) begin : g_pin
      always_ff @(posedge i_clock) begin
        if (i_rst) begin
          meta[g] <= 1'b0;
          o_level[g] <= 1'b0;
          o_level_prev[g] <= 1'b0;
        end else begin
          meta[g] <= i_pin[g];
          o_level[g] <= meta[g];
          o_level_prev[g] <= o_level[g];
        end
      end
    end
  endgenerate

endmodule

//--- src/pin_output_stage.sv
`timescale 1ns/1ns
module pin_output_stage #(
  parameter int WIDTH = 10
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [WIDTH-1:0] i_src,
  input wire logic [WIDTH-1:0] i_enable,
  output logic [WIDTH-1:0] o_out,
  output logic [WIDTH-1:0] o_oe
);

  // ---------------------------------------------------------------------------
  // registered drivers
  // ---------------------------------------------------------------------------
  // registered drive
  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_out <= '0;
    end else begin
      o_out <= i_src & i_enable;
    end
  end

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_oe <= '0;
    end else begin
      o_oe <= i_enable;
    end
  end

endmodule

//--- testbench/function_pin_source.sv
`timescale 1ns/1ns
// ----
// outside trigger sources on the function pins
// ----
module function_pin_source
  import timing_pin_router_pkg::*;
(
  input wire logic [NUM_PINS-1:0] i_drive,
  input wire logic [NUM_PINS-1:0] i_value,
  input wire logic [NUM_PINS-1:0] i_dev_oe,
  input wire logic [NUM_PINS-1:0] i_dev_out,
  output logic [NUM_PINS-1:0] o_pin
);
  logic [NUM_PINS-1:0] ext_on;
  assign ext_on = i_drive & ~i_dev_oe;
  // released lines float to the pull-up level
  assign o_pin = (i_dev_oe & i_dev_out) | (ext_on & i_value) |
    ~(i_dev_oe | ext_on);
endmodule

//--- testbench/timing_pin_router_sva.sv
`timescale 1ns/1ns
module timing_pin_router_chk
  import timing_pin_router_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [ADDR_W-1:0] i_addr,
  input wire logic [DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [DATA_W-1:0] o_rdata,
  input wire logic [NUM_PINS-1:0] o_function_pin_out,
  input wire logic [NUM_PINS-1:0] o_function_pin_oe,
  input wire logic [NUM_PINS-1:0] i_pin_drive_src,
  input wire logic [NUM_DEDICATED-1:0] i_dedicated_src,
  input wire logic [NUM_DEDICATED-1:0] o_dedicated_out,
  input wire logic [NUM_DEDICATED-1:0] o_dedicated_oe,
  input wire logic [NUM_ROUTES-1:0] i_internal_timing,
  input wire logic [NUM_ROUTES-1:0] o_timing_signal,
  input wire logic [NUM_ROUTES-1:0] o_route_external
);
  default clocking @(posedge i_clock);
  endclocking
  default disable iff (i_rst);
  // ----
  // driver enables
  // ----
  sequence s_pin_en_wr;
    i_wr && i_addr == PIN_DRIVE_EN_ADDR;
  endsequence
  sequence s_ded_en_wr;
    i_wr && i_addr == DEDICATED_EN_ADDR;
  endsequence
  property p_pin_en;
    s_pin_en_wr |-> ##2 o_function_pin_oe == NUM_PINS'($past(i_wdata, 2));
  endproperty
  a_pin_en: assert property (p_pin_en)
    else $error("pin enable not applied");
  property p_ded_en;
    s_ded_en_wr |-> ##2
      o_dedicated_oe == NUM_DEDICATED'($past(i_wdata, 2));
  endproperty
  a_ded_en: assert property (p_ded_en)
    else $error("dedicated enable not applied");
  property p_reset_idle;
    $fell(i_rst) |-> o_function_pin_oe == '0 && o_dedicated_oe == '0;
  endproperty
  a_reset_idle: assert property (p_reset_idle)
    else $error("driver on after reset");
  property p_out_gated;
    (o_function_pin_out & ~o_function_pin_oe) == '0;
  endproperty
  a_out_gated: assert property (p_out_gated)
    else $error("disabled pin drives high");
  property p_pin_src;
    ((o_function_pin_out ^ $past(i_pin_drive_src)) & o_function_pin_oe) == '0;
  endproperty
  a_pin_src: assert property (p_pin_src)
    else $error("pin not carrying its source");
  property p_ded_src;
    ((o_dedicated_out ^ $past(i_dedicated_src)) & o_dedicated_oe) == '0;
  endproperty
  a_ded_src: assert property (p_ded_src)
    else $error("dedicated pin not carrying its source");
  // ----
  // routes and reads
  // ----
  property p_internal;
    ((o_timing_signal ^ $past(i_internal_timing)) & ~o_route_external) == '0;
  endproperty
  a_internal: assert property (p_internal)
    else $error("internal route not passed through");
  property p_rd_idle;
    !$past(i_rd) |-> o_rdata == '0;
  endproperty
  a_rd_idle: assert property (p_rd_idle)
    else $error("read data outside read slot");
  property p_rd_pins;
    i_rd && i_addr == PIN_LEVEL_ADDR |=> o_rdata[DATA_W-1:NUM_PINS] == '0;
  endproperty
  a_rd_pins: assert property (p_rd_pins)
    else $error("pin level read wider than ten pins");
endmodule
bind timing_pin_router timing_pin_router_chk i_chk (.*);

//--- testbench/tb_timing_pin_router.sv
`timescale 1ns/1ns
module tb_timing_pin_router import timing_pin_router_pkg::*;;
  logic clock = 1'b0;
  logic rst = 1'b1;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic rd_d = 1'b0;
  logic [ADDR_W-1:0] addr = 8'h00;
  logic [DATA_W-1:0] wdata = 32'h0, rdata;
  logic [NUM_PINS-1:0] pin, pout, poe, en, psrc = 10'h0;
  logic [NUM_PINS-1:0] ext_drv = 10'h3ff, ext_val = 10'h3ff;
  logic [NUM_DEDICATED-1:0] dsrc = 5'h0, dout, doe, den;
  logic [NUM_ROUTES-1:0] itim = 13'h0, tsig, rext, pol;
  logic [DATA_W-1:0] exp_q[$];
  int err_count = 0, tests_run = 0, cycles = 0, v, lp;
  int pcnt[NUM_ROUTES] = '{default: 0};
  int plast[NUM_ROUTES], sel[NUM_ROUTES], tf[NUM_PINS], tr[NUM_PINS];
  int wid[2] = '{40, 3};

  timing_pin_router i_timing_pin_router (
    .i_clock(clock), .i_rst(rst), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_function_pin_in(pin),
    .o_function_pin_out(pout), .o_function_pin_oe(poe),
    .i_pin_drive_src(psrc), .i_dedicated_src(dsrc), .o_dedicated_out(dout),
    .o_dedicated_oe(doe), .i_internal_timing(itim),
    .o_timing_signal(tsig), .o_route_external(rext));
  function_pin_source i_function_pin_source (
    .i_drive(ext_drv), .i_value(ext_val), .i_dev_oe(poe),
    .i_dev_out(pout), .o_pin(pin));

  initial begin
    forever #2 clock = ~clock;
  end
  // ----
  // shared tasks
  // ----
  task automatic chk(string nm, logic [DATA_W-1:0] e, logic [DATA_W-1:0] s);
    tests_run++;
    if (s !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  // each access takes two cycles so strobes never re-assert in one step
  task automatic wr_reg(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    wr <= 1'b0;
    @(posedge clock);
  endtask
  task automatic rd_reg(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] e);
    exp_q.push_back(e);
    rd <= 1'b1;
    addr <= a;
    @(posedge clock);
    rd <= 1'b0;
    @(posedge clock);
  endtask
  task automatic pulse(int p, int w);
    tf[p] = int'($time);
    ext_val[p] <= 1'b0;
    repeat (w) @(posedge clock);
    tr[p] = int'($time);
    ext_val[p] <= 1'b1;
    repeat (30) @(posedge clock);
  endtask
  // ----
  // result watcher
  // ----
  always @(posedge clock) begin
    rd_d <= rd;
    cycles <= cycles + 1;
    if (rd_d) begin
      chk("rdata", exp_q.pop_front(), rdata);
    end
    for (int r = 0; r < NUM_ROUTES; r++) begin
      if (tsig[r] === 1'b1) begin
        pcnt[r]++;
        plast[r] = int'($time);
      end
    end
    if (cycles == 8000) begin
      err_count++;
      conclude();
    end
  end
  // ----
  // main sequence
  // ----
  initial begin
    void'($urandom(32'h6679));
    repeat (12) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    @(negedge clock);
    chk("idle_oe", 32'h0, 32'({poe, doe}));
    @(posedge clock);
    rd_reg(PIN_DRIVE_EN_ADDR, 32'h0);
    rd_reg(8'h80, 32'h0);
    $display("test reset done");
    en = NUM_PINS'($urandom);
    den = NUM_DEDICATED'($urandom);
    psrc <= NUM_PINS'($urandom);
    dsrc <= NUM_DEDICATED'($urandom);
    wr_reg(PIN_DRIVE_EN_ADDR, 32'(en));
    wr_reg(DEDICATED_EN_ADDR, 32'(den));
    repeat (2) @(posedge clock);
    chk("pin_oe", 32'(en), 32'(poe));
    chk("pin_out", 32'(psrc & en), 32'(pout));
    chk("ded_out", 32'(dsrc & den), 32'(dout));
    chk("ded_oe", 32'(den), 32'(doe));
    rd_reg(PIN_LEVEL_ADDR, {22'h0, psrc & en | ~en});
    wr_reg(PIN_DRIVE_EN_ADDR, 32'h0);
    wr_reg(DEDICATED_EN_ADDR, 32'h0);
    $display("test drive done");
    for (int r = 0; r < NUM_ROUTES; r++) begin
      sel[r] = $urandom % NUM_PINS;
      pol[r] = 1'($urandom);
      wr_reg(8'(ROUTE_CFG_BASE + 4 * r), 32'(sel[r] + 16 + pol[r] * 32));
    end
    wr_reg(EVENT_SEEN_ADDR, 32'h0000_1fff);
    rd_reg(EVENT_SEEN_ADDR, 32'h0);
    // long pulses first, then the shortest legal width
    foreach (wid[k]) begin
      for (int p = 0; p < NUM_PINS; p++) begin
        pulse(p, wid[k]);
      end
      for (int r = 0; r < NUM_ROUTES; r++) begin
        chk("pulse_count", 32'(k + 1), 32'(pcnt[r]));
        v = plast[r] - (pol[r] ? tf[sel[r]] : tr[sel[r]]);
        if (k == 0) begin
          chk("pulse_time", 32'h1, 32'(v == 4 * CLK_PERIOD_NS));
        end
      end
    end
    rd_reg(EVENT_SEEN_ADDR, 32'h0000_1fff);
    $display("test edge done");
    for (lp = 0; lp < 2; lp++) begin
      wr_reg(8'h24, 32'h55 + lp * 32);
      repeat (3) begin
        v = $urandom % 2;
        ext_val[5] <= 1'(v);
        repeat (8) @(posedge clock);
        rd_reg(ROUTE_STATE_ADDR, 32'(v ^ lp) << 5);
      end
    end
    // a select past the last pin reads as a low line
    wr_reg(8'h24, 32'h0000_007f);
    repeat (4) @(posedge clock);
    rd_reg(ROUTE_STATE_ADDR, 32'h0000_0020);
    $display("test level done");
    wr_reg(8'h40, 32'h0);
    itim <= NUM_ROUTES'($urandom);
    repeat (3) @(posedge clock);
    chk("internal", 32'(itim[12]), 32'(tsig[12]));
    chk("route_ext", 32'h0000_0fff, 32'(rext));
    $display("test internal done");
    conclude();
  end
endmodule
